// >>> logic/sacs_params.svh
// Offsets, field positions, reset values and counts of the agent capability
// and status register bank.
// Assumes inclusion by bare name from the package and design files.
`ifndef SACS_PARAMS_SVH
`define SACS_PARAMS_SVH

`define SACS_CAP_STATUS_OFFSET  12'h004
`define SACS_POOL_CFG_OFFSET    12'h008
`define SACS_ADDR_BITS          12
`define SACS_BIT_READY          0
`define SACS_BIT_ATOMIC         1
`define SACS_BIT_MAINT          2
`define SACS_BIT_RSVD           3
`define SACS_POOL_LSB           4
`define SACS_POOL_MSB           9
`define SACS_POOL_MAX           6'h3F
`define SACS_POOL_MIN           6'h01
`define SACS_POOL_RESET         6'h01
`define SACS_RESP_OKAY          2'h0
`define SACS_RESP_SLVERR        2'h2
`define SACS_RESP_DECERR        2'h3

`endif

// >>> logic/sacs_pkg.sv
// Types shared by the agent capability and status register bank.
// Assumes sacs_params.svh is on the include path.
`include "sacs_params.svh"

package sacs_pkg;

    typedef enum logic [1:0] {
        SACS_W_IDLE,
        SACS_W_RESP
    } sacs_wstate_t;

    typedef struct packed {
        logic       ready;
        logic       atomic;
        logic       maint;
        logic [5:0] pools;
    } sacs_status_t;

endpackage : sacs_pkg

// >>> logic/sacs_status_if.sv
// Carries the settled status fields from the qualifier to the bus slave.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ns
`default_nettype none

interface sacs_status_if;
    sacs_pkg::sacs_status_t status;
    modport source (output status);
    modport sink   (input  status);
endinterface : sacs_status_if

`default_nettype wire

// >>> logic/sacs_qualify.sv
// Qualifies raw agent readiness and capability inputs into register fields.
// Assumes pin inputs come from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none
`include "sacs_params.svh"

module sacs_qualify (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          training_done,
    input  wire logic          sizes_valid,
    input  wire logic          atomic_capable,
    input  wire logic          cache_maint_capable,
    input  wire logic [5:0]    pool_count_req,
    input  wire logic [5:0]    mem_type_count,
    sacs_status_if.source      out
);

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] stable;
        sacs_pkg::sacs_status_t st;
    } sacs_q_state_t;

    sacs_q_state_t q;
    sacs_q_state_t next_q;
    logic [5:0]    pools;

    always_comb begin
        next_q    = q;
        next_q.s1 = {training_done & sizes_valid, atomic_capable,
                     cache_maint_capable};
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        for (int i = 0; i < 3; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                next_q.stable[i] = q.s3[i];
            end
        end
        pools = pool_count_req;
        if (pools < mem_type_count) begin
            pools = mem_type_count;
        end
        if (pools > `SACS_POOL_MAX) begin
            pools = `SACS_POOL_MAX;
        end
        if (pools < `SACS_POOL_MIN) begin
            pools = `SACS_POOL_MIN;
        end
        // Pool count is latched until ready, then frozen so software sees
        // a consistent size once discovery is allowed
        if (!q.st.ready) begin
            next_q.st.pools = pools;
        end
        next_q.st.ready  = q.stable[2];
        next_q.st.atomic = q.stable[1];
        next_q.st.maint  = q.stable[0];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q          <= '0;
            q.st.pools <= `SACS_POOL_RESET;
        end else begin
            q <= next_q;
        end
    end

    assign out.status = q.st;

endmodule : sacs_qualify

`default_nettype wire

// >>> logic/sacs_top.sv
// Agent capability and status register bank with an AXI4-Lite slave.
// Assumes the raw capability pins are static or slowly changing straps.
`timescale 1ns/1ns
`default_nettype none
`include "sacs_params.svh"

module sacs_top (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       training_done,
    input  wire logic                       sizes_valid,
    input  wire logic                       atomic_capable,
    input  wire logic                       cache_maint_capable,
    input  wire logic [5:0]                 pool_count_req,
    input  wire logic [5:0]                 mem_type_count,
    output logic      [5:0]                 pool_count,
    input  wire logic [`SACS_ADDR_BITS-1:0] s_axi_awaddr,
    input  wire logic [2:0]                 s_axi_awprot,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [`SACS_ADDR_BITS-1:0] s_axi_araddr,
    input  wire logic [2:0]                 s_axi_arprot,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        sacs_pkg::sacs_wstate_t wstate;
        logic                   aw_got;
        logic                   w_got;
        logic [`SACS_ADDR_BITS-1:0] awaddr;
        logic                   awready;
        logic                   wready;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
        logic [5:0]             pool_out;
    } sacs_top_state_t;

    sacs_top_state_t r;
    sacs_top_state_t next_r;
    sacs_status_if   stat_bus ();
    sacs_pkg::sacs_status_t st;
    logic            aw_fire;
    logic            w_fire;

    sacs_qualify u_qualify (
        .aclk                (aclk),
        .aresetn             (aresetn),
        .training_done       (training_done),
        .sizes_valid         (sizes_valid),
        .atomic_capable      (atomic_capable),
        .cache_maint_capable (cache_maint_capable),
        .pool_count_req      (pool_count_req),
        .mem_type_count      (mem_type_count),
        .out                 (stat_bus.source)
    );

    assign st = stat_bus.status;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    always_comb begin
        next_r          = r;
        next_r.pool_out = st.pools;
        aw_fire         = s_axi_awvalid & r.awready;
        w_fire          = s_axi_wvalid & r.wready;
        unique case (r.wstate)
            sacs_pkg::SACS_W_IDLE: begin
                next_r.awready = ~r.aw_got & ~aw_fire;
                next_r.wready  = ~r.w_got & ~w_fire;
                if (aw_fire) begin
                    next_r.aw_got = 1'b1;
                    next_r.awaddr = s_axi_awaddr;
                end
                if (w_fire) begin
                    next_r.w_got = 1'b1;
                end
                if ((r.aw_got | aw_fire) & (r.w_got | w_fire)) begin
                    // Every register is read-only; writes are discarded
                    if ((aw_fire ? s_axi_awaddr : r.awaddr) ==
                        `SACS_CAP_STATUS_OFFSET) begin
                        next_r.bresp = `SACS_RESP_SLVERR;
                    end else begin
                        next_r.bresp = `SACS_RESP_DECERR;
                    end
                    next_r.bvalid  = 1'b1;
                    next_r.awready = 1'b0;
                    next_r.wready  = 1'b0;
                    next_r.wstate  = sacs_pkg::SACS_W_RESP;
                end
            end
            sacs_pkg::SACS_W_RESP: begin
                if (s_axi_bready) begin
                    next_r.bvalid  = 1'b0;
                    next_r.aw_got  = 1'b0;
                    next_r.w_got   = 1'b0;
                    next_r.awready = 1'b1;
                    next_r.wready  = 1'b1;
                    next_r.wstate  = sacs_pkg::SACS_W_IDLE;
                end
            end
        endcase

        if (r.rvalid) begin
            if (s_axi_rready) begin
                next_r.rvalid  = 1'b0;
                next_r.arready = 1'b1;
            end
        end else if (s_axi_arvalid & r.arready) begin
            next_r.arready = 1'b0;
            next_r.rvalid  = 1'b1;
            next_r.rdata   = 32'h0000_0000;
            next_r.rresp   = `SACS_RESP_OKAY;
            if (s_axi_araddr == `SACS_CAP_STATUS_OFFSET) begin
                next_r.rdata[`SACS_BIT_READY]  = st.ready;
                next_r.rdata[`SACS_BIT_ATOMIC] = st.atomic;
                next_r.rdata[`SACS_BIT_MAINT]  = st.maint;
                next_r.rdata[`SACS_BIT_RSVD]   = 1'b0;
                next_r.rdata[`SACS_POOL_MSB:`SACS_POOL_LSB] = st.pools;
            end else if (s_axi_araddr == `SACS_POOL_CFG_OFFSET) begin
                next_r.rdata[5:0] = st.pools;
            end else begin
                next_r.rresp = `SACS_RESP_DECERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r          <= '0;
            r.wstate   <= sacs_pkg::SACS_W_IDLE;
            r.awready  <= 1'b1;
            r.wready   <= 1'b1;
            r.arready  <= 1'b1;
            r.pool_out <= `SACS_POOL_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign s_axi_awready = r.awready;
    assign s_axi_wready  = r.wready;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = r.rresp;
    assign pool_count    = r.pool_out;

endmodule : sacs_top

`default_nettype wire

// >>> bench/sacs_chk.sv
// Checker of the agent status bank: read channel, write refusals, fields.
// Assumes binding into sacs_top, one clock, synchronous low reset.
`timescale 1ns/1ns
`default_nettype none
module sacs_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        training_done,
    input wire logic        sizes_valid,
    input wire logic [5:0]  mem_type_count,
    input wire logic [5:0]  pool_count,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_bvalid,
    input wire logic [1:0]  s_axi_bresp
);
    // ----------------------------------------
    // Read address tracking
    // ----------------------------------------
    logic rd4;
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready)
            rd4 <= (s_axi_araddr == 12'h004);
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_take; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_rwait; s_axi_rvalid && !s_axi_rready; endsequence
    sequence s_rkeep; s_axi_rvalid && $stable(s_axi_rdata); endsequence
    sequence s_st; s_axi_rvalid && rd4; endsequence
    sequence s_rdy; s_st ##0 s_axi_rdata[0]; endsequence
    sequence s_zero;
        s_axi_rdata[31:10] == 22'h0 && !s_axi_rdata[3];
    endsequence
    sequence s_trained;
        $past(training_done, 3) && $past(sizes_valid, 3);
    endsequence
    AST_RLAT: assert property (s_take |=> s_axi_rvalid)
        else $error("read answer not one cycle after address");
    AST_RHOLD: assert property (s_rwait |=> s_rkeep)
        else $error("read data dropped before rready");
    AST_ARBLK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address accepted while answer pending");
    AST_BERR: assert property (s_axi_bvalid |-> s_axi_bresp != 2'h0)
        else $error("write to read-only bank answered okay");
    AST_NZ: assert property (pool_count != 6'h00)
        else $error("pool count zero");
    AST_RSVD: assert property (s_st |-> s_zero)
        else $error("reserved bits set");
    AST_POOL: assert property (s_st |-> s_axi_rdata[9:4] == pool_count)
        else $error("pool field differs from pool count");
    AST_GE: assert property (s_rdy |-> pool_count >= mem_type_count)
        else $error("fewer pools than memory types");
    AST_RDY: assert property (s_rdy |-> s_trained)
        else $error("ready shown before training and sizes");
endmodule : sacs_chk
bind sacs_top sacs_chk u_chk (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .training_done  (training_done),
    .sizes_valid    (sizes_valid),
    .mem_type_count (mem_type_count),
    .pool_count     (pool_count),
    .s_axi_araddr   (s_axi_araddr),
    .s_axi_arvalid  (s_axi_arvalid),
    .s_axi_arready  (s_axi_arready),
    .s_axi_rvalid   (s_axi_rvalid),
    .s_axi_rready   (s_axi_rready),
    .s_axi_rdata    (s_axi_rdata),
    .s_axi_bvalid   (s_axi_bvalid),
    .s_axi_bresp    (s_axi_bresp)
);
`default_nettype wire

// >>> bench/slave_agent_capability_status_tb.sv
// Self-checking bench of the agent status bank over AXI4-Lite.
// Assumes sacs_top and sacs_chk are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module slave_agent_capability_status_tb;
    logic        aclk = 1'b0, aresetn = 1'b0, trn = 1'b0, szv = 1'b0;
    logic        atm = 1'b0, mnt = 1'b0, awv = 1'b0, wv = 1'b0;
    logic        bry = 1'b0, arv = 1'b0, rry = 1'b0, awr, wrd, bv, arr, rv;
    logic [5:0]  req = 6'h00, mtc = 6'h00, pc, exp_pc;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h0, rd_d;
    logic [1:0]  br, rr;
    logic [33:0] q[$];
    int          n_fail = 0, total_checks = 0, k;
    always #50 aclk = ~aclk;
    sacs_top uut (.aclk(aclk), .aresetn(aresetn), .training_done(trn),
        .sizes_valid(szv), .atomic_capable(atm), .cache_maint_capable(mnt),
        .pool_count_req(req), .mem_type_count(mtc), .pool_count(pc),
        .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rry));
    // ----------------------------------------
    // Report and compare
    // ----------------------------------------
    task test_done;
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done
    task cmp(input logic [33:0] g, input logic [33:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask : cmp
    task tmo;
        if (++k > 100) begin
            n_fail++;
            test_done;
        end
    endtask : tmo
    always @(posedge aclk) begin
        if (rv === 1'b1 && rry === 1'b1) cmp({rr, rd_d}, q.pop_front());
        if (bv === 1'b1 && bry === 1'b1) cmp({br, 32'h0}, q.pop_front());
    end
    // ----------------------------------------
    // Bus master
    // ----------------------------------------
    task rd(input logic [11:0] a, input logic [33:0] e);
        q.push_back(e);
        ara <= a;
        arv <= 1'b1;
        k = 0;
        do begin @(posedge aclk); tmo; end while (arr !== 1'b1);
        arv <= 1'b0;
        repeat ($urandom % 3) @(posedge aclk);
        rry <= 1'b1;
        k = 0;
        do begin @(posedge aclk); tmo; end while (rv !== 1'b1);
        rry <= 1'b0;
    endtask : rd
    task wr(input logic [11:0] a, input logic [1:0] e);
        q.push_back({e, 32'h0});
        awa <= a;
        wd <= $urandom;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            tmo;
            if (awr === 1'b1) awv <= 1'b0;
            if (wrd === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1);
    endtask : wr
    function automatic logic [33:0] word(input logic r);
        return {24'h0, exp_pc, 1'b0, mnt, atm, r};
    endfunction : word
    initial begin
        k = $urandom(32'h6eb9);
        for (int i = 0; i < 4; i++) begin
            aresetn <= 1'b0;
            trn <= 1'b0;
            szv <= 1'b0;
            req <= (i == 0) ? 6'h00 : (i == 1) ? 6'h05 :
                   (i == 2) ? 6'h3F : 6'($urandom);
            mtc <= (i == 0) ? 6'h00 : (i == 1) ? 6'h09 :
                   (i == 2) ? 6'h02 : 6'($urandom);
            atm <= i[0];
            mnt <= i[1];
            repeat (10) @(posedge aclk);
            aresetn <= 1'b1;
            if (i[0]) szv <= 1'b1;
            else trn <= 1'b1;
            repeat (10) @(posedge aclk);
            exp_pc = (req > mtc) ? req : mtc;
            if (exp_pc == 6'h00) exp_pc = 6'h01;
            rd(12'h004, word(1'b0));
            trn <= 1'b1;
            szv <= 1'b1;
            repeat (10) @(posedge aclk);
            rd(12'h004, word(1'b1));
            rd(12'h008, {28'h0, exp_pc});
            cmp({28'h0, pc}, {28'h0, exp_pc});
            $display("test %0d done", i);
        end
        wr(12'h004, 2'h2);
        wr(12'h00C, 2'h3);
        rd(12'h004, word(1'b1));
        rd(12'h010, {2'h3, 32'h0});
        $display("test 4 done");
        test_done;
    end
endmodule : slave_agent_capability_status_tb
`default_nettype wire
